/* File: inc/mcp_pkg.sv */
// shared constants of the mmu coprocessor command port
package mcp_pkg;
    // data and cpu-space address widths
    localparam int DATA_W     = 32;
    localparam int ADDR_W     = 20;
    localparam int ENTRIES    = 64;
    localparam int BKPTS      = 8;
    localparam int OPCODE_W   = 16;
    // cpu-space address fields
    localparam int SPACE_LSB  = 16;
    localparam int CPID_LSB   = 13;
    localparam int SLOT_LSB   = 1;
    localparam int BKNUM_LSB  = 2;
    localparam logic [3:0] SPACE_BKPT   = 4'h0;
    localparam logic [3:0] SPACE_COPROC = 4'h2;
    localparam logic [2:0] OWN_CPID     = 3'h0;
    // interface register slots
    localparam logic [3:0] SLOT_RESPONSE = 4'h0;
    localparam logic [3:0] SLOT_COMMAND  = 4'h5;
    localparam logic [3:0] SLOT_OPERAND  = 4'h8;
    // command word fields
    localparam int OP_LSB     = 12;
    localparam int DIR_BIT    = 11;
    localparam int BYADDR_BIT = 9;
    localparam int FC_LSB     = 5;
    localparam int SEL_LSB    = 0;
    // command operation codes
    localparam logic [3:0] OP_REGMOVE  = 4'h0;
    localparam logic [3:0] OP_VALIDATE = 4'h1;
    localparam logic [3:0] OP_PROBE_RD = 4'h2;
    localparam logic [3:0] OP_PROBE_WR = 4'h3;
    localparam logic [3:0] OP_PRELD_RD = 4'h4;
    localparam logic [3:0] OP_PRELD_WR = 4'h5;
    localparam logic [3:0] OP_FLUSH    = 4'h6;
    localparam logic [3:0] OP_FLUSHALL = 4'h7;
    localparam logic [3:0] OP_FLUSHRT  = 4'h8;
    localparam logic [3:0] OP_FLUSHSH  = 4'h9;
    localparam logic [3:0] OP_EXPORT   = 4'ha;
    localparam logic [3:0] OP_IMPORT   = 4'hb;
    localparam logic [3:0] OP_CBRANCH  = 4'hc;
    localparam logic [3:0] OP_CDBRANCH = 4'hd;
    localparam logic [3:0] OP_CSET     = 4'he;
    localparam logic [3:0] OP_CTRAP    = 4'hf;
    // response codes
    localparam logic [31:0] RESP_IDLE      = 32'h0000_0000;
    localparam logic [31:0] RESP_DONE      = 32'h0000_0001;
    localparam logic [31:0] RESP_NEED_OPND = 32'h0000_0002;
    localparam logic [31:0] RESP_SEND_OPND = 32'h0000_0003;
    localparam logic [31:0] RESP_TRAP      = 32'h0000_0004;
    localparam logic [31:0] RESP_COND_F    = 32'h0000_0005;
    localparam logic [31:0] RESP_COND_T    = 32'h0000_0006;
    // internal register select
    localparam logic [4:0] SEL_LEVEL  = 5'h00;
    localparam logic [4:0] SEL_STATUS = 5'h01;
    localparam logic [4:0] SEL_ROOT   = 5'h02;
    localparam int SEL_BKPT_BIT = 4;
    localparam int SEL_CTRL_BIT = 3;
    // status register bits
    localparam int ST_HIT      = 15;
    localparam int ST_SHARED   = 14;
    localparam int ST_MODIFIED = 13;
    localparam int ST_USED     = 12;
    localparam int ST_PRIVFLT  = 11;
    localparam int ST_WRITE    = 10;
    // breakpoint control fields
    localparam int BKC_MODE_BIT = 8;
    localparam int BKC_W        = 9;
    // logical address fields
    localparam int PAGE_LSB  = 12;
    localparam int TAG_W     = 20;
    localparam int LEVEL_LSB = 29;
    // reset values
    localparam logic [2:0]  LEVEL_RST  = 3'h0;
    localparam logic [2:0]  ROOT_RST   = 3'h0;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [8:0]  BKC_RST    = 9'h000;
endpackage

/* File: src/mcp_bkpt_store.sv */
// replacement opcode store with registered read
`timescale 1ns/1ps
module mcp_bkpt_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic                     clock,
    input  wire logic                     wrEn,
    input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input  wire logic [WIDTH-1:0]         wrData,
    input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic      [WIDTH-1:0]         rdData
);
    logic [WIDTH-1:0] store [DEPTH];

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("mcp_bkpt_store: bad geometry");
        end
    endgenerate

    // no reset: contents are software-loaded before use
    always_ff @(posedge clock) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
        rdData <= store[rdAddr];
    end
endmodule

/* File: src/mcp_port.sv */
// cpu-space responder of the paged mmu coprocessor
`timescale 1ns/1ps
// Operation
// [RULE_01] processor reads fixed address on breakpoint
// [RULE_02] answer breakpoint read: opcode+acks or bus error
// [RULE_03] mode: always exception, or n-times opcode
// [RULE_04] count decrements per opcode; zero gives error
// [RULE_05] processor passes instructions via register accesses
// [RULE_06] register move reads or writes internal register
// [RULE_07] validate traps when address needs more privilege
// [RULE_08] probe read/write loads status for address
// [RULE_09] preload read installs entry, history marks used
// [RULE_10] preload write installs entry, history marks modified
// [RULE_11] selective flush by function code, optionally address
// [RULE_12] flush all invalidates every cache entry
// [RULE_13] flush by root drops root and its entries; code invalidates entries matching the root only, root_reg is kept
// [RULE_14] shared flush drops shared entries by match
// [RULE_15] export state; import reloads the exported state
// [RULE_16] evaluate conditions for branch, set, trap ops
// [RULE_17] standard bus cycles, clock-rate independent handshake
// [RULE_18] processor computes all effective addresses
// [RULE_19] processor moves operands; unit only walks tables
// [RULE_20] processor performs trap when unit requests it
// [RULE_21] at most eight coprocessors, one such unit
// [RULE_22] processor drives coprocessor id zero on address
// [RULE_23] processor writes command, then reads response
module mcp_port
    import mcp_pkg::*;
#(
    parameter int NUM_ENTRIES = ENTRIES
) (
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              reqStrobe,
    input  wire logic              reqWrite,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [DATA_W-1:0] reqWData,
    output logic      [DATA_W-1:0] readData,
    output logic                   dataAck,
    output logic                   sizeAck32,
    output logic                   busErr,
    output logic                   historyStrobe,
    output logic                   historyModified,
    output logic      [DATA_W-1:0] historyAddr
);
    localparam int IDX_W = $clog2(NUM_ENTRIES);
    localparam int BK_W  = $clog2(BKPTS);

    if (NUM_ENTRIES < 2 || (NUM_ENTRIES & (NUM_ENTRIES - 1)) != 0)
    begin : g_bad
        $error("mcp_port: NUM_ENTRIES must be a power of two");
    end

    typedef enum logic [1:0] {CMD_IDLE, CMD_WAIT_WR, CMD_WAIT_RD} mcp_cmd_e;
    typedef enum logic [1:0] {K_BKPT, K_DATA, K_ERROR} mcp_kind_e;

    mcp_cmd_e          cmdState_reg, cmdState_next;
    logic [15:0]       cmdWord_reg;
    logic [DATA_W-1:0] resp_reg, resp_next;
    logic [2:0]        level_reg;
    logic [2:0]        root_reg;
    logic [15:0]       status_reg;
    logic [IDX_W-1:0]  victim_reg;
    logic [BKC_W-1:0]  bkCtrl_reg [BKPTS];
    logic              s1Valid_reg;
    mcp_kind_e         s1Kind_reg;
    logic [DATA_W-1:0] s1Data_reg;
    logic              s1Supply_reg;
    logic              s1FromMem_reg;

    // request decode; one request in flight at a time
    wire        canTake   = reqStrobe & ~s1Valid_reg;
    wire [3:0]  spaceType = reqAddr[SPACE_LSB +: 4];
    wire [2:0]  cpId      = reqAddr[CPID_LSB +: 3];
    wire [3:0]  slot      = reqAddr[SLOT_LSB +: 4];
    wire [BK_W-1:0] bkNum = reqAddr[BKNUM_LSB +: BK_W];
    wire isBkpt = canTake & ~reqWrite & (spaceType == SPACE_BKPT); // [RULE_01]
    wire isCop  = canTake & (spaceType == SPACE_COPROC)
                & (cpId == OWN_CPID);               // [RULE_21] [RULE_22]
    wire cmdWrite = isCop & reqWrite & (slot == SLOT_COMMAND);  // [RULE_23]
    wire respRead = isCop & ~reqWrite & (slot == SLOT_RESPONSE);
    wire opWrite  = isCop & reqWrite & (slot == SLOT_OPERAND)
                  & (cmdState_reg == CMD_WAIT_WR);
    wire opRead   = isCop & ~reqWrite & (slot == SLOT_OPERAND)
                  & (cmdState_reg == CMD_WAIT_RD);
    wire copError = isCop & ~(cmdWrite | respRead | opWrite | opRead);

    // fields of a fresh command word
    wire [3:0] newOp     = reqWData[OP_LSB +: 4];
    wire       newDir    = reqWData[DIR_BIT];
    wire       newByAddr = reqWData[BYADDR_BIT];
    wire isCond = (newOp == OP_CBRANCH) | (newOp == OP_CDBRANCH)
                | (newOp == OP_CSET) | (newOp == OP_CTRAP);
    wire needRd = ((newOp == OP_REGMOVE) & newDir) | (newOp == OP_EXPORT);
    wire needWr = ((newOp == OP_REGMOVE) & ~newDir)
                | (newOp == OP_VALIDATE) | (newOp == OP_PROBE_RD)
                | (newOp == OP_PROBE_WR) | (newOp == OP_PRELD_RD)
                | (newOp == OP_PRELD_WR) | (newOp == OP_FLUSHRT)
                | (newOp == OP_IMPORT)
                | (((newOp == OP_FLUSH) | (newOp == OP_FLUSHSH))
                   & newByAddr);

    // the acting command: fresh if it needs no operand, else latched
    wire        immGo   = cmdWrite & ~needRd & ~needWr & ~isCond;
    wire        actGo   = immGo | opWrite;
    wire [15:0] actWord = cmdWrite ? reqWData[15:0] : cmdWord_reg;
    wire [3:0]  actOp   = actWord[OP_LSB +: 4];
    wire [3:0]  actFc   = actWord[FC_LSB +: 4];
    wire [4:0]  actSel  = actWord[SEL_LSB +: 5];
    wire        actByA  = actWord[BYADDR_BIT] & opWrite;
    wire [TAG_W-1:0] opTag = reqWData[PAGE_LSB +: TAG_W];
    wire [2:0]  opLevel = reqWData[LEVEL_LSB +: 3];
    wire [2:0]  opRoot  = reqWData[2:0];

    wire doValidate = opWrite & (actOp == OP_VALIDATE);
    wire doProbe    = opWrite & ((actOp == OP_PROBE_RD)
                    | (actOp == OP_PROBE_WR));
    wire doPreload  = opWrite & ((actOp == OP_PRELD_RD)
                    | (actOp == OP_PRELD_WR));
    wire isWriteOp  = (actOp == OP_PROBE_WR) | (actOp == OP_PRELD_WR);
    wire doFlushSel = actGo & (actOp == OP_FLUSH);
    wire doFlushAll = actGo & (actOp == OP_FLUSHALL);
    wire doFlushRt  = actGo & (actOp == OP_FLUSHRT);
    wire doFlushSh  = actGo & (actOp == OP_FLUSHSH);
    wire doImport   = actGo & (actOp == OP_IMPORT);
    wire doRegWr    = actGo & (actOp == OP_REGMOVE);
    wire selBkpt    = actSel[SEL_BKPT_BIT];
    wire selCtrl    = actSel[SEL_CTRL_BIT];
    wire [BK_W-1:0] selBk = actSel[BK_W-1:0];
    // lower level number means more privilege
    wire privFault  = opLevel < level_reg;                       // [RULE_07]

    // translation cache entries, one per generate slice
    logic [NUM_ENTRIES-1:0] entValid, entShared, entMod, entUsed;
    logic [NUM_ENTRIES-1:0] hitVec, flushVec, installVec;
    logic [3:0]       entFc   [NUM_ENTRIES];
    logic [TAG_W-1:0] entTag  [NUM_ENTRIES];
    logic [2:0]       entRoot [NUM_ENTRIES];
    wire anyHit = |hitVec;

    genvar gi;
        for (gi = 0; gi < NUM_ENTRIES; gi++) begin : g_ent
            wire fcHit  = entValid[gi] & (entFc[gi] == actFc);
            wire tagHit = entTag[gi] == opTag;
            assign hitVec[gi] = fcHit & tagHit & (entRoot[gi] == root_reg);
            assign installVec[gi] = doPreload & ~anyHit
                                  & (victim_reg == IDX_W'(gi));
            assign flushVec[gi] = doFlushAll                     // [RULE_12]
                | (doFlushSel & fcHit & (~actByA | tagHit))      // [RULE_11]
                | (doFlushSh & fcHit & entShared[gi]
                   & (~actByA | tagHit))                         // [RULE_14]
                | (doFlushRt & (entRoot[gi] == opRoot));         // [RULE_13]
            // install beats a flush landing in the same cycle
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    entValid[gi]  <= 1'b0;
                    entShared[gi] <= 1'b0;
                    entMod[gi]    <= 1'b0;
                    entUsed[gi]   <= 1'b0;
                    entFc[gi]     <= 4'h0;
                    entTag[gi]    <= '0;
                    entRoot[gi]   <= 3'h0;
                end else if (installVec[gi]) begin
                    entValid[gi]  <= 1'b1;                   // [RULE_09]
                    entShared[gi] <= actSel[0];
                    entMod[gi]    <= isWriteOp;              // [RULE_10]
                    entUsed[gi]   <= 1'b1;
                    entFc[gi]     <= actFc;
                    entTag[gi]    <= opTag;
                    entRoot[gi]   <= root_reg;
                end else if (flushVec[gi]) begin
                    entValid[gi]  <= 1'b0;
                end else if (doPreload & hitVec[gi]) begin
                    entUsed[gi]   <= 1'b1;
                    entMod[gi]    <= entMod[gi] | isWriteOp;
                end
            end
        end

    wire hitShared = |(hitVec & entShared);
    wire hitMod    = |(hitVec & entMod);
    wire hitUsed   = |(hitVec & entUsed);

    // condition evaluated on the status register
    wire [3:0] condIdx  = {1'b1, reqWData[2:0]};
    wire       condTrue = status_reg[condIdx] ^ reqWData[3];     // [RULE_16]

    // breakpoint control and counting
    wire [BKC_W-1:0] bkCtl    = bkCtrl_reg[bkNum];
    wire             bkSupply = bkCtl[BKC_MODE_BIT]
                              & (bkCtl[7:0] != 8'h00);           // [RULE_03]
        for (gi = 0; gi < BKPTS; gi++) begin : g_bk
            wire wrCtl = doRegWr & selBkpt & selCtrl
                       & (selBk == BK_W'(gi));
            wire decr  = isBkpt & bkSupply & (bkNum == BK_W'(gi));
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    bkCtrl_reg[gi] <= BKC_RST;
                end else if (wrCtl) begin
                    bkCtrl_reg[gi] <= reqWData[BKC_W-1:0];      // [RULE_06]
                end else if (decr) begin
                    bkCtrl_reg[gi] <= bkCtrl_reg[gi] - 9'h001;  // [RULE_04]
                end
            end
        end

    wire bkDataWr = doRegWr & selBkpt & ~selCtrl;
    wire [BK_W-1:0] memRdAddr = isBkpt ? bkNum : selBk;
    logic [OPCODE_W-1:0] memRdData;

    mcp_bkpt_store #(
        .WIDTH (OPCODE_W),
        .DEPTH (BKPTS)
    ) u_store (
        .clock  (clock),
        .wrEn   (bkDataWr),
        .wrAddr (selBk),
        .wrData (reqWData[OPCODE_W-1:0]),
        .rdAddr (memRdAddr),
        .rdData (memRdData)
    );

    // operand read value for register move or state export
    logic [DATA_W-1:0] opReadVal;
    wire [4:0] latSel = cmdWord_reg[SEL_LSB +: 5];
    always_comb begin
        opReadVal = '0;
        if (cmdWord_reg[OP_LSB +: 4] == OP_EXPORT) begin
            opReadVal = {status_reg, 13'h0000, level_reg};       // [RULE_15]
        end else if (latSel[SEL_BKPT_BIT] & latSel[SEL_CTRL_BIT]) begin
            opReadVal = {23'h000000, bkCtrl_reg[latSel[BK_W-1:0]]};
        end else if (latSel == SEL_LEVEL) begin
            opReadVal = {29'h00000000, level_reg};
        end else if (latSel == SEL_STATUS) begin
            opReadVal = {16'h0000, status_reg};
        end else if (latSel == SEL_ROOT) begin
            opReadVal = {29'h00000000, root_reg};
        end
    end

    // command sequencing and response
    always_comb begin
        cmdState_next = cmdState_reg;
        resp_next     = resp_reg;
        if (cmdWrite) begin
            if (needWr) begin
                cmdState_next = CMD_WAIT_WR;
                resp_next     = RESP_NEED_OPND;                 // [RULE_19]
            end else if (needRd) begin
                cmdState_next = CMD_WAIT_RD;
                resp_next     = RESP_SEND_OPND;
            end else if (isCond) begin
                cmdState_next = CMD_IDLE;
                if (newOp == OP_CTRAP) begin
                    resp_next = condTrue ? RESP_TRAP : RESP_DONE; // [RULE_16]
                end else begin
                    resp_next = condTrue ? RESP_COND_T : RESP_COND_F;
                end
            end else begin
                cmdState_next = CMD_IDLE;
                resp_next     = RESP_DONE;
            end
        end else if (opWrite) begin
            cmdState_next = CMD_IDLE;
            resp_next = (doValidate & privFault) ? RESP_TRAP
                                                 : RESP_DONE;   // [RULE_07]
        end else if (opRead) begin
            cmdState_next = CMD_IDLE;
            resp_next     = RESP_DONE;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmdState_reg <= CMD_IDLE;
            resp_reg     <= RESP_IDLE;
            cmdWord_reg  <= 16'h0000;
        end else begin
            cmdState_reg <= cmdState_next;
            resp_reg     <= resp_next;
            if (cmdWrite) begin
                cmdWord_reg <= reqWData[15:0];
            end
        end
    end

    // internal registers written by register move, probe, validate and import
    wire levelWr = (doRegWr & ~selBkpt & (actSel == SEL_LEVEL)) | doImport;
    wire [15:0] probeStatus = {anyHit, hitShared, hitMod, hitUsed,
                               privFault, isWriteOp, 10'h000};  // [RULE_08]
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            level_reg  <= LEVEL_RST;
            root_reg   <= ROOT_RST;
            status_reg <= STATUS_RST;
        end else begin
            if (levelWr) begin
                level_reg <= reqWData[2:0];                      // [RULE_15]
            end
            if (doRegWr & ~selBkpt & (actSel == SEL_ROOT)) begin
                root_reg <= reqWData[2:0];
            end
            if (doProbe | doValidate) begin
                status_reg <= probeStatus;
            end else if (doImport) begin
                status_reg <= reqWData[31:16];
            end else if (doRegWr & ~selBkpt & (actSel == SEL_STATUS)) begin
                status_reg <= reqWData[15:0];
            end
        end
    end

    // round-robin victim pointer, moves only on a miss install
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            victim_reg <= '0;
        end else if (doPreload & ~anyHit) begin
            victim_reg <= victim_reg + IDX_W'(1);
        end
    end

    // stage one: hold the kind of answer while the store reads
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s1Valid_reg   <= 1'b0;
            s1Kind_reg    <= K_DATA;
            s1Data_reg    <= '0;
            s1Supply_reg  <= 1'b0;
            s1FromMem_reg <= 1'b0;
        end else begin
            s1Valid_reg   <= isBkpt | isCop;
            s1Kind_reg    <= isBkpt ? K_BKPT : (copError ? K_ERROR : K_DATA);
            s1Data_reg    <= respRead ? resp_reg
                           : (opRead ? opReadVal : '0);
            s1Supply_reg  <= bkSupply;
            s1FromMem_reg <= opRead & latSel[SEL_BKPT_BIT]
                           & ~latSel[SEL_CTRL_BIT];
        end
    end

    // answer stage: acknowledge with data, or bus error
    wire bkOk   = s1Valid_reg & (s1Kind_reg == K_BKPT) & s1Supply_reg;
    wire ackNxt = bkOk | (s1Valid_reg & (s1Kind_reg == K_DATA));  // [RULE_17]
    wire errNxt = s1Valid_reg & ~ackNxt;                        // [RULE_02]
    wire useMem = (s1Kind_reg == K_BKPT) | s1FromMem_reg;
    wire [DATA_W-1:0] dataNxt = useMem ? {16'h0000, memRdData} : s1Data_reg;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dataAck         <= 1'b0;
            sizeAck32       <= 1'b0;
            busErr          <= 1'b0;
            readData        <= '0;
            historyStrobe   <= 1'b0;
            historyModified <= 1'b0;
            historyAddr     <= '0;
        end else begin
            dataAck   <= ackNxt;                                 // [RULE_02]
            sizeAck32 <= ackNxt;
            busErr    <= errNxt;
            readData  <= ackNxt ? dataNxt : '0;
            historyStrobe   <= doPreload;                        // [RULE_09]
            historyModified <= doPreload & isWriteOp;            // [RULE_10]
            if (doPreload) begin
                historyAddr <= reqWData;
            end
        end
    end
endmodule

/* File: testbench/mcp_port_assertions.sv */
// port checker of the mmu coprocessor command port
`timescale 1ns/1ps
module mcp_port_assertions
    import mcp_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst_b,
    input wire logic              reqStrobe,
    input wire logic              reqWrite,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [DATA_W-1:0] readData,
    input wire logic              dataAck,
    input wire logic              sizeAck32,
    input wire logic              busErr,
    input wire logic              historyStrobe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire logic [3:0] space = reqAddr[SPACE_LSB+:4];
    sequence s_take;
        reqStrobe && !$past(reqStrobe);
    endsequence
    sequence s_answer;
        dataAck || busErr;
    endsequence
    a_size_pair: assert property (sizeAck32 == dataAck)
        else $error("size ack differs from data ack");
    a_ack_err_excl: assert property (!(dataAck && busErr))
        else $error("ack and bus error together");
    a_answer_cause: assert property (s_answer |-> $past(reqStrobe, 2))
        else $error("answer without request two cycles before");
    a_bkpt_answered: assert property (s_take ##0
        (!reqWrite && space == SPACE_BKPT) |-> ##2 (dataAck ^ busErr))
        else $error("breakpoint read left unanswered");
    a_foreign_silent: assert property (reqStrobe && space != SPACE_BKPT
        && space != SPACE_COPROC |-> ##2 !(dataAck || busErr))
        else $error("foreign space access answered");
    a_err_single: assert property (busErr |=> !busErr)
        else $error("bus error longer than one cycle");
    a_data_quiet: assert property (!dataAck |-> readData == '0)
        else $error("read data without ack");
    a_history_pulse: assert property (historyStrobe |->
        $past(reqStrobe) && $past(reqWrite) ##1 dataAck)
        else $error("history update out of step");
endmodule
bind mcp_port mcp_port_assertions u_chk (.clock(clock), .rst_b(rst_b),
    .reqStrobe(reqStrobe), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .readData(readData), .dataAck(dataAck), .sizeAck32(sizeAck32),
    .busErr(busErr), .historyStrobe(historyStrobe));

/* File: testbench/mcp_cpu_model.sv */
// processor-side bus model issuing cpu-space requests
`timescale 1ns/1ps
module mcp_cpu_model
    import mcp_pkg::*;
(
    input  wire logic              clock,
    output logic                   reqStrobe,
    output logic                   reqWrite,
    output logic      [ADDR_W-1:0] reqAddr,
    output logic      [DATA_W-1:0] reqWData
);
    initial {reqStrobe, reqWrite, reqAddr, reqWData} = '0;
    // spaced four cycles so no request lands in flight
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        @(negedge clock);
        reqStrobe <= 1'b1;
        reqWrite <= w;
        reqAddr <= a;
        reqWData <= d;
        @(negedge clock);
        reqStrobe <= 1'b0;
        // released lines must not keep the last value
        reqAddr <= ~a;
        reqWData <= ~d;
        repeat (2) @(negedge clock);
    endtask
endmodule

/* File: testbench/mcp_port_tb.sv */
// self-checking bench of the mmu coprocessor command port
`timescale 1ns/1ps
module mcp_port_tb;
    import mcp_pkg::*;
    logic clock, rst_b, reqStrobe, reqWrite, dataAck, sizeAck32, busErr;
    logic historyStrobe, historyModified;
    logic [ADDR_W-1:0] reqAddr;
    logic [DATA_W-1:0] reqWData, readData, historyAddr, rnd, pa;
    logic [64:0]       notes[$];
    logic [64:0]       n;
    int                num_errors, checked, hist;
    mcp_port u_dut (.*);
    // single unit on the bus
    mcp_cpu_model u_cpu (.*);
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [19:0] ca(input logic [3:0] s);
        return {SPACE_COPROC, OWN_CPID, 8'h0, s, 1'b0};
    endfunction
    task automatic check(input string nm, input logic [33:0] s,
                         input logic [33:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [19:0] a,
        input logic [31:0] d, input logic e, input logic [31:0] m,
        input logic [31:0] x);
        notes.push_back({e, m, x});
        u_cpu.acc(w, a, d);
    endtask
    task automatic resp(input logic [31:0] r);
        xfer(1'b0, ca(SLOT_RESPONSE), '0, 1'b0, '1, r);
    endtask
    task automatic cmd(input logic [15:0] w, input logic [31:0] r);
        xfer(1'b1, ca(SLOT_COMMAND), {16'h0, w}, 1'b0, '0, '0);
        resp(r);
    endtask
    task automatic put(input logic [31:0] v, input logic [31:0] r);
        xfer(1'b1, ca(SLOT_OPERAND), v, 1'b0, '0, '0);
        resp(r);
    endtask
    task automatic get(input logic [31:0] m, input logic [31:0] v);
        xfer(1'b0, ca(SLOT_OPERAND), '0, 1'b0, m, v);
        resp(RESP_DONE);
    endtask
    always @(negedge clock) begin
        if (dataAck === 1'b1 || busErr === 1'b1) begin
            if (notes.size() == 0) check("spare answer", 1, 0);
            else begin
                n = notes.pop_front();
                check("answer", {busErr, sizeAck32, readData & n[63:32]},
                      {n[64], ~n[64], n[31:0]});
            end
        end
        if (historyStrobe === 1'b1) begin
            hist++;
            check("history", {historyModified, historyAddr}, {1'b1, pa});
        end
    end
    initial begin
        #(40 * 3000);
        num_errors++;
        results();
    end
    initial begin
        rst_b = 1'b0;
        rnd = lfsr(32'hb36d9603);
        pa = {3'h7, rnd[28:0]};
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        for (int k = 0; k < BKPTS; k++)
            xfer(1'b0, {SPACE_BKPT, 11'h0, 3'(k), 2'b0}, '0, 1'b1, '0, '0);
        $display("test breakpoint default done");
        cmd({OP_REGMOVE, 1'b0, 6'h0, 5'h13}, RESP_NEED_OPND);
        put({16'h0, rnd[15:0]}, RESP_DONE);
        cmd({OP_REGMOVE, 1'b0, 6'h0, 5'h1b}, RESP_NEED_OPND);
        put(32'h0000_0102, RESP_DONE);
        for (int i = 0; i < 3; i++)
            xfer(1'b0, {SPACE_BKPT, 11'h0, 3'h3, 2'b0}, '0, i == 2,
                 32'h0000_ffff, i == 2 ? 32'h0 : {16'h0, rnd[15:0]});
        $display("test breakpoint count done");
        cmd({OP_REGMOVE, 1'b0, 6'h0, SEL_LEVEL}, RESP_NEED_OPND);
        put(32'h3, RESP_DONE);
        cmd({OP_REGMOVE, 1'b1, 6'h0, SEL_LEVEL}, RESP_SEND_OPND);
        get(32'h7, 32'h3);
        cmd({OP_EXPORT, 12'h0}, RESP_SEND_OPND);
        get(32'h7, 32'h3);
        cmd({OP_VALIDATE, 12'h0}, RESP_NEED_OPND);
        put({3'h2, 29'h0}, RESP_TRAP);
        cmd({OP_VALIDATE, 12'h0}, RESP_NEED_OPND);
        put({3'h5, 29'h0}, RESP_DONE);
        $display("test level and validate done");
        cmd({OP_PRELD_WR, 12'h0}, RESP_NEED_OPND);
        put(pa, RESP_DONE);
        for (int i = 0; i < 2; i++) begin
            cmd({OP_PROBE_RD, 12'h0}, RESP_NEED_OPND);
            put(pa, RESP_DONE);
            cmd({OP_REGMOVE, 1'b1, 6'h0, SEL_STATUS}, RESP_SEND_OPND);
            get(32'h8000, i == 0 ? 32'h8000 : 32'h0);
            cmd({OP_CBRANCH, 12'h7}, i == 0 ? RESP_COND_T : RESP_COND_F);
            cmd({OP_CSET, 12'hf}, i == 0 ? RESP_COND_F : RESP_COND_T);
            if (i == 0) cmd({OP_FLUSHALL, 12'h0}, RESP_DONE);
        end
        $display("test preload probe flush done");
        xfer(1'b0, ca(4'h3), '0, 1'b1, '0, '0);
        u_cpu.acc(1'b0, {4'h1, 16'h0}, '0);
        u_cpu.acc(1'b1, {SPACE_BKPT, 16'h0}, '0);
        check("unanswered", 34'(notes.size()), 34'h0);
        check("history count", 34'(hist), 34'h1);
        $display("test refusals done");
        results();
    end
endmodule
